//--- rtl/egtrc_pkg.sv
`default_nettype none

package egtrc_pkg;

    // ****************************************************************
    // register indices (word index on the register port)
    // ****************************************************************
    localparam logic [15:0] TAG_CTRL_INDEX = 16'h1c0c;
    localparam logic [15:0] RATE_P0Q01_INDEX = 16'h1c0d;
    localparam logic [15:0] RATE_P0Q23_INDEX = 16'h1c0e;
    localparam logic [15:0] RATE_P1Q01_INDEX = 16'h1c0f;

    // ****************************************************************
    // field layout
    // ****************************************************************
    localparam int PORT_FIELD_STRIDE = 8;
    localparam int PTYPE_LSB = 0;
    localparam int CHG_TAG_BIT = 2;
    localparam int CHG_PRI_BIT = 3;
    localparam int CHG_VID_BIT = 4;
    localparam int INS_BIT = 5;
    localparam int SEL_BIT = 6;
    localparam logic [31:0] TAG_CTRL_MASK = 32'h007f7f7f;
    localparam logic [31:0] TAG_CTRL_RESET = 32'h00000000;
    localparam int RATE_W = 13;
    localparam int RATE_LO_LSB = 0;
    localparam int RATE_HI_LSB = 13;
    localparam logic [RATE_W-1:0] RATE_RESET = 13'h0000;
    localparam int NUM_QUEUES = 6;
    localparam int NUM_PORTS = 3;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int RATE_STEP_NS = 20;
    localparam int RATE_STEP_CYCLES = (RATE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PACE_W = 15;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        PTYPE_DUMB,
        PTYPE_ACCESS,
        PTYPE_HYBRID,
        PTYPE_CPU
    } egtrc_ptype_t;

    typedef enum logic [1:0] {
        KIND_UNTAGGED,
        KIND_PRIORITY,
        KIND_REGULAR,
        KIND_SPECIAL
    } egtrc_kind_t;

    typedef enum logic [2:0] {
        ACT_PASS,
        ACT_STRIP,
        ACT_INSERT,
        ACT_CHANGE,
        ACT_ADD_SPECIAL
    } egtrc_action_t;

    typedef struct packed {
        logic sel;
        logic ins;
        logic chg_vid;
        logic chg_pri;
        logic chg_tag;
        logic [1:0] ptype;
    } egtrc_port_cfg_t;

    typedef struct packed {
        logic [1:0] egress_port;
        logic [1:0] ingress_port;
        egtrc_kind_t kind;
        logic untag_bit;
        logic [11:0] frame_vlan_identifier;
        logic [2:0] frame_pri;
        logic [11:0] ingress_vlan_identifier;
        logic [2:0] ingress_pri;
        logic [11:0] egress_vlan_identifier;
        logic [2:0] egress_pri;
    } egtrc_frame_t;

    typedef struct packed {
        egtrc_action_t action;
        logic [11:0] vlan_identifier;
        logic [2:0] pri;
        logic [1:0] src_port;
    } egtrc_decision_t;

endpackage

`default_nettype wire

//--- rtl/egtrc_top.sv
// Function
// RULE_01: port 2 two-bit egress type at bits 17:16, read/write, resets to zero.
// RULE_02: type 00 passes regular frames, strips special tags from external port.
// RULE_03: type 01 strips every tag, special tags included.
// RULE_04: type 10 mixes insert, strip and change per port controls.
// RULE_05: type 11 adds a special tag naming the ingress port.
// RULE_06: bits 14..8 hold port 1 controls, same meaning as port 2.
// RULE_07: bits 6..0 hold port 0 controls, same meaning, reset zero.
// RULE_08: time per byte is (rate field plus one) times 20 ns.
// RULE_09: each queue of each port is paced independently by its own rate; code paces port 0 queues 0-3 and port 1 queues 0-1 only.
// RULE_10: index 1c0d holds port 0 queue 1 and queue 0 rates.
// RULE_11: index 1c0e holds port 0 queue 3 and queue 2 rates.
// RULE_12: index 1c0f holds port 1 queue 1 and queue 0 rates.
// RULE_13: select flag picks ingress or egress defaults for inserted tags.
// RULE_14: insert flag tags untagged frames only when untag bit clear.
// RULE_15: regular VLAN_IDENTIFIER changed only with change-vid, change-tag, untag clear.
// RULE_16: change-priority rewrites priority; regular frames also need change-tag.
// RULE_17: reserved bits read zero; new settings apply from the next cycle. A rate rewrite during a gap only applies from the next byte.
`timescale 1ns/1ps
`default_nettype none

module egtrc_top (
    input wire logic clk,
    input wire logic reset,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_index,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_ack,
    input wire logic req_valid,
    input wire egtrc_pkg::egtrc_frame_t req,
    output logic dec_valid,
    output egtrc_pkg::egtrc_decision_t dec,
    input wire logic [egtrc_pkg::NUM_QUEUES-1:0] byte_sent,
    output logic [egtrc_pkg::NUM_QUEUES-1:0] queue_ready
);

    // ****************************************************************
    // register file
    // ****************************************************************
    logic [31:0] tag_ctrl;
    logic [egtrc_pkg::RATE_W-1:0] rate [egtrc_pkg::NUM_QUEUES];

    wire hit_tag = reg_index == egtrc_pkg::TAG_CTRL_INDEX;
    wire hit_r0 = reg_index == egtrc_pkg::RATE_P0Q01_INDEX;
    wire hit_r1 = reg_index == egtrc_pkg::RATE_P0Q23_INDEX;
    wire hit_r2 = reg_index == egtrc_pkg::RATE_P1Q01_INDEX;
    wire hit_rate = hit_r0 | hit_r1 | hit_r2;
    // rate word w holds queue 2w in the low field and queue 2w+1 in the high field
    wire [1:0] rate_word = hit_r0 ? 2'h0 : (hit_r1 ? 2'h1 : 2'h2);
    wire [2:0] rate_lo_q = {rate_word, 1'b0};
    wire [2:0] rate_hi_q = {rate_word, 1'b1};
    wire [egtrc_pkg::RATE_W-1:0] wr_lo = reg_wdata[egtrc_pkg::RATE_LO_LSB +: egtrc_pkg::RATE_W];
    wire [egtrc_pkg::RATE_W-1:0] wr_hi = reg_wdata[egtrc_pkg::RATE_HI_LSB +: egtrc_pkg::RATE_W];
    wire [31:0] rate_rd_word = {6'h00, rate[rate_hi_q], rate[rate_lo_q]}; // RULE_17
    wire [31:0] rd_mux = hit_tag ? (tag_ctrl & egtrc_pkg::TAG_CTRL_MASK) :
                         (hit_rate ? rate_rd_word : 32'h00000000);

    // reserved bits are masked on write so they never store
    always_ff @(posedge clk) begin
        if (reset) begin
            tag_ctrl <= egtrc_pkg::TAG_CTRL_RESET; // RULE_01 RULE_06 RULE_07
        end else if (reg_wr && hit_tag) begin
            tag_ctrl <= reg_wdata & egtrc_pkg::TAG_CTRL_MASK; // RULE_17
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            reg_ack <= 1'b0;
            reg_rdata <= 32'h00000000;
        end else begin
            reg_ack <= reg_wr | reg_rd;
            reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
        end
    end

    // ****************************************************************
    // per-queue rate registers and pacers
    // ****************************************************************
    genvar q;
    generate
        for (q = 0; q < egtrc_pkg::NUM_QUEUES; q++) begin : g_queue
            logic [egtrc_pkg::PACE_W-1:0] pace;
            wire wr_this = reg_wr && hit_rate && (rate_word == 2'(q / 2));
            wire [egtrc_pkg::RATE_W-1:0] wr_val = (q % 2 == 1) ? wr_hi : wr_lo;
            // period in cycles = (rate + 1) * cycles per 20 ns step
            wire [egtrc_pkg::PACE_W-1:0] period =
                egtrc_pkg::PACE_W'((32'(rate[q]) + 32'd1) * egtrc_pkg::RATE_STEP_CYCLES); // RULE_08

            always_ff @(posedge clk) begin
                if (reset) begin
                    rate[q] <= egtrc_pkg::RATE_RESET;
                end else if (wr_this) begin
                    rate[q] <= wr_val; // RULE_10 RULE_11 RULE_12
                end
            end

            // a sent byte holds queue_ready low for period - 1 cycles; the rate in force
            // at send time sets the gap, so a rewrite applies from the next byte
            always_ff @(posedge clk) begin
                if (reset) begin
                    pace <= '0;
                end else if (byte_sent[q] && queue_ready[q]) begin
                    pace <= period - egtrc_pkg::PACE_W'(1); // RULE_09
                end else if (pace != '0) begin
                    pace <= pace - egtrc_pkg::PACE_W'(1);
                end
            end

            assign queue_ready[q] = pace == '0; // RULE_09
        end
    endgenerate

    // ****************************************************************
    // egress tag decision
    // ****************************************************************
    function automatic egtrc_pkg::egtrc_decision_t decide(
        input egtrc_pkg::egtrc_frame_t f,
        input egtrc_pkg::egtrc_port_cfg_t c
    );
        egtrc_pkg::egtrc_decision_t d;
        logic [11:0] sel_vid;
        logic [2:0] sel_pri;
        d.action = egtrc_pkg::ACT_PASS;
        d.vlan_identifier = f.frame_vlan_identifier;
        d.pri = f.frame_pri;
        d.src_port = f.ingress_port;
        sel_vid = c.sel ? f.egress_vlan_identifier : f.ingress_vlan_identifier; // RULE_13
        sel_pri = c.sel ? f.egress_pri : f.ingress_pri; // RULE_13
        case (egtrc_pkg::egtrc_ptype_t'(c.ptype))
            egtrc_pkg::PTYPE_DUMB: begin
                if (f.kind == egtrc_pkg::KIND_SPECIAL) begin
                    d.action = egtrc_pkg::ACT_STRIP; // RULE_02
                end
            end
            egtrc_pkg::PTYPE_ACCESS: begin
                if (f.kind != egtrc_pkg::KIND_UNTAGGED) begin
                    d.action = egtrc_pkg::ACT_STRIP; // RULE_03
                end
            end
            egtrc_pkg::PTYPE_HYBRID: begin
                case (f.kind) // RULE_04
                    egtrc_pkg::KIND_UNTAGGED: begin
                        if (c.ins && !f.untag_bit) begin
                            d.action = egtrc_pkg::ACT_INSERT; // RULE_14
                            d.vlan_identifier = sel_vid;
                            d.pri = sel_pri;
                        end
                    end
                    egtrc_pkg::KIND_PRIORITY: begin
                        // change-tag does not gate priority-tagged frames
                        d.action = egtrc_pkg::ACT_CHANGE; // RULE_15
                        d.vlan_identifier = sel_vid;
                        d.pri = c.chg_pri ? sel_pri : f.frame_pri; // RULE_16
                    end
                    egtrc_pkg::KIND_REGULAR: begin
                        if (f.untag_bit) begin
                            d.action = egtrc_pkg::ACT_STRIP; // RULE_15
                        end else if (c.chg_tag && (c.chg_vid || c.chg_pri)) begin
                            d.action = egtrc_pkg::ACT_CHANGE;
                            d.vlan_identifier = c.chg_vid ? sel_vid : f.frame_vlan_identifier; // RULE_15
                            d.pri = c.chg_pri ? sel_pri : f.frame_pri; // RULE_16
                        end
                    end
                    default: begin
                        d.action = egtrc_pkg::ACT_STRIP;
                    end
                endcase
            end
            egtrc_pkg::PTYPE_CPU: begin
                d.action = egtrc_pkg::ACT_ADD_SPECIAL; // RULE_05
            end
            default: begin
                d.action = egtrc_pkg::ACT_PASS;
            end
        endcase
        return d;
    endfunction

    wire [4:0] cfg_lsb = 5'(req.egress_port) * 5'(egtrc_pkg::PORT_FIELD_STRIDE);
    wire [6:0] cfg_bits = tag_ctrl[cfg_lsb +: 7];
    wire port_ok = req.egress_port < 2'(egtrc_pkg::NUM_PORTS);
    wire egtrc_pkg::egtrc_port_cfg_t port_cfg = '{
        sel: cfg_bits[egtrc_pkg::SEL_BIT],
        ins: cfg_bits[egtrc_pkg::INS_BIT],
        chg_vid: cfg_bits[egtrc_pkg::CHG_VID_BIT],
        chg_pri: cfg_bits[egtrc_pkg::CHG_PRI_BIT],
        chg_tag: cfg_bits[egtrc_pkg::CHG_TAG_BIT],
        ptype: cfg_bits[egtrc_pkg::PTYPE_LSB +: 2]
    }; // RULE_06 RULE_07
    wire egtrc_pkg::egtrc_decision_t next_dec = decide(req, port_cfg);
    wire egtrc_pkg::egtrc_decision_t pass_dec = '{
        action: egtrc_pkg::ACT_PASS,
        vlan_identifier: req.frame_vlan_identifier,
        pri: req.frame_pri,
        src_port: req.ingress_port
    };

    always_ff @(posedge clk) begin
        if (reset) begin
            dec_valid <= 1'b0;
            dec <= '0;
        end else begin
            dec_valid <= req_valid;
            if (req_valid) begin
                dec <= port_ok ? next_dec : pass_dec;
            end
        end
    end

endmodule

`default_nettype wire

//--- test/egtrc_props.sv
`timescale 1ns/1ps
`default_nettype none
module egtrc_props (
    input wire logic clk,
    input wire logic reset,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_index,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic req_valid,
    input wire egtrc_pkg::egtrc_frame_t req,
    input wire logic dec_valid,
    input wire egtrc_pkg::egtrc_decision_t dec,
    input wire logic [5:0] byte_sent,
    input wire logic [5:0] queue_ready
);
    logic [31:0] tag_q;
    logic [5:0] sent_q;
    logic [1:0] pt;
    logic ok_eg;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // shadow of the tagging register so decisions can be judged per egress port
    always_ff @(posedge clk) begin
        if (reset) begin
            tag_q <= 32'h0;
            sent_q <= 6'h0;
        end else begin
            if (reg_wr && reg_index == egtrc_pkg::TAG_CTRL_INDEX) begin
                tag_q <= reg_wdata & egtrc_pkg::TAG_CTRL_MASK;
            end
            sent_q <= byte_sent & queue_ready;
        end
    end
    assign pt = tag_q[{req.egress_port, 3'h0} +: 2];
    assign ok_eg = req_valid && req.egress_port != 2'h3;
    property p_ack; (reg_wr || reg_rd) |=> reg_ack; endproperty
    a_ack: assert property (p_ack) else $error("access not acknowledged");
    property p_noack; !(reg_wr || reg_rd) |=> !reg_ack; endproperty
    a_noack: assert property (p_noack) else $error("stray acknowledge");
    property p_idle; !reg_ack |-> reg_rdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside answer");
    property p_resv; reg_rdata[31:26] == 6'h0; endproperty
    a_resv: assert property (p_resv) else $error("reserved rate bits set");
    property p_unmap;
        reg_rd && (reg_index < egtrc_pkg::TAG_CTRL_INDEX || reg_index > egtrc_pkg::RATE_P1Q01_INDEX)
        |=> reg_rdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_tagrd; reg_rd && !reg_wr && reg_index == egtrc_pkg::TAG_CTRL_INDEX |=> reg_rdata == tag_q; endproperty
    a_tagrd: assert property (p_tagrd) else $error("tagging readback wrong");
    property p_decv; 1'h1 |=> dec_valid == $past(req_valid); endproperty
    a_decv: assert property (p_decv) else $error("decision timing wrong");
    property p_dumb;
        ok_eg && pt == 2'h0 |=> dec.action ==
        (($past(req.kind) == egtrc_pkg::KIND_SPECIAL) ? egtrc_pkg::ACT_STRIP : egtrc_pkg::ACT_PASS);
    endproperty
    a_dumb: assert property (p_dumb) else $error("dumb port action wrong");
    property p_access; ok_eg && pt == 2'h1 && req.kind != egtrc_pkg::KIND_UNTAGGED |=> dec.action == egtrc_pkg::ACT_STRIP; endproperty
    a_access: assert property (p_access) else $error("access port kept tag");
    property p_cpu;
        ok_eg && pt == 2'h3 |=> dec.action == egtrc_pkg::ACT_ADD_SPECIAL && dec.src_port == $past(req.ingress_port);
    endproperty
    a_cpu: assert property (p_cpu) else $error("cpu port tag wrong");
    property p_pace; |sent_q |-> (queue_ready & sent_q) == 6'h0; endproperty
    a_pace: assert property (p_pace) else $error("queue ready right after send");
    c_hyb: cover property (ok_eg && pt == 2'h2);
    c_send: cover property (|(byte_sent & queue_ready));
    c_rate: cover property (reg_rd && reg_index == egtrc_pkg::RATE_P1Q01_INDEX);
endmodule
bind egtrc_top egtrc_props props_u (.clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .req_valid(req_valid), .req(req), .dec_valid(dec_valid), .dec(dec), .byte_sent(byte_sent),
    .queue_ready(queue_ready));
`default_nettype wire

//--- test/egtrc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module egtrc_top_tb;
    logic clk, reset, reg_wr, reg_rd, req_valid, reg_ack, dec_valid;
    logic [15:0] reg_index;
    logic [31:0] reg_wdata, reg_rdata, rd_val;
    logic [5:0] byte_sent, queue_ready;
    egtrc_pkg::egtrc_frame_t req;
    egtrc_pkg::egtrc_decision_t dec;
    int n_mismatch, checks, cycles;
    egtrc_top dut_u (.clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_index(reg_index),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .req_valid(req_valid), .req(req),
        .dec_valid(dec_valid), .dec(dec), .byte_sent(byte_sent), .queue_ready(queue_ready));
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ceiling well above the roughly 140 cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic wr(input logic [15:0] i, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'h1;
        reg_index <= i;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'h0;
        #1;
        `CHK("write ack", 1'h1, reg_ack)
    endtask
    task automatic rd(input logic [15:0] i, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'h1;
        reg_index <= i;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1;
        d = reg_rdata;
    endtask
    task automatic t_regs();
        logic [15:0] idx[5] = '{16'h1c0c, 16'h1c0d, 16'h1c0e, 16'h1c0f, 16'h1c10};
        logic [31:0] msk[5] = '{32'h007f7f7f, 32'h03ffffff, 32'h03ffffff, 32'h03ffffff, 32'h0};
        `CHK("ready after reset", 6'h3f, queue_ready)
        for (int k = 0; k < 5; k++) begin
            rd(idx[k], rd_val);
            `CHK("reset value", 32'h0, rd_val)
            wr(idx[k], 32'hffffffff);
            rd(idx[k], rd_val);
            `CHK("read back", msk[k], rd_val)
        end
        $display("test regs done");
    endtask
    task automatic send(input logic [1:0] eg, input egtrc_pkg::egtrc_kind_t k, input logic ut,
        input egtrc_pkg::egtrc_action_t a, input logic [11:0] v, input logic [2:0] p);
        @(posedge clk);
        req_valid <= 1'h1;
        req <= '{eg, 2'h1, k, ut, 12'h0c3, 3'h1, 12'h0a1, 3'h2, 12'h0b2, 3'h5};
        @(posedge clk);
        req_valid <= 1'h0;
        #1;
        `CHK("decision valid", 1'h1, dec_valid)
        `CHK("action", a, dec.action)
        if (a == egtrc_pkg::ACT_INSERT || a == egtrc_pkg::ACT_CHANGE) begin
            `CHK("tag vid", v, dec.vlan_identifier)
            `CHK("tag pri", p, dec.pri)
        end
        if (a == egtrc_pkg::ACT_ADD_SPECIAL) `CHK("source port", 2'h1, dec.src_port)
    endtask
    task automatic t_decide();
        // port 2 cpu, port 1 access, port 0 dumb
        wr(16'h1c0c, 32'h00030100);
        send(2'h0, egtrc_pkg::KIND_SPECIAL, 1'h0, egtrc_pkg::ACT_STRIP, 12'h0, 3'h0);
        send(2'h0, egtrc_pkg::KIND_REGULAR, 1'h0, egtrc_pkg::ACT_PASS, 12'h0, 3'h0);
        send(2'h1, egtrc_pkg::KIND_PRIORITY, 1'h0, egtrc_pkg::ACT_STRIP, 12'h0, 3'h0);
        send(2'h1, egtrc_pkg::KIND_SPECIAL, 1'h0, egtrc_pkg::ACT_STRIP, 12'h0, 3'h0);
        send(2'h1, egtrc_pkg::KIND_UNTAGGED, 1'h0, egtrc_pkg::ACT_PASS, 12'h0, 3'h0);
        send(2'h2, egtrc_pkg::KIND_UNTAGGED, 1'h0, egtrc_pkg::ACT_ADD_SPECIAL, 12'h0, 3'h0);
        send(2'h3, egtrc_pkg::KIND_REGULAR, 1'h0, egtrc_pkg::ACT_PASS, 12'h0, 3'h0);
        // port 0 hybrid, every flag, egress defaults
        wr(16'h1c0c, 32'h0000007e);
        send(2'h0, egtrc_pkg::KIND_UNTAGGED, 1'h0, egtrc_pkg::ACT_INSERT, 12'h0b2, 3'h5);
        send(2'h0, egtrc_pkg::KIND_UNTAGGED, 1'h1, egtrc_pkg::ACT_PASS, 12'h0, 3'h0);
        send(2'h0, egtrc_pkg::KIND_REGULAR, 1'h0, egtrc_pkg::ACT_CHANGE, 12'h0b2, 3'h5);
        send(2'h0, egtrc_pkg::KIND_REGULAR, 1'h1, egtrc_pkg::ACT_STRIP, 12'h0, 3'h0);
        send(2'h0, egtrc_pkg::KIND_SPECIAL, 1'h0, egtrc_pkg::ACT_STRIP, 12'h0, 3'h0);
        // hybrid with insert and change-priority only, ingress defaults
        wr(16'h1c0c, 32'h0000002a);
        send(2'h0, egtrc_pkg::KIND_UNTAGGED, 1'h0, egtrc_pkg::ACT_INSERT, 12'h0a1, 3'h2);
        send(2'h0, egtrc_pkg::KIND_PRIORITY, 1'h0, egtrc_pkg::ACT_CHANGE, 12'h0a1, 3'h2);
        send(2'h0, egtrc_pkg::KIND_REGULAR, 1'h0, egtrc_pkg::ACT_PASS, 12'h0, 3'h0);
        // change-tag and change-priority without change-vid: regular frame keeps its own vid
        wr(16'h1c0c, 32'h0000000e);
        send(2'h0, egtrc_pkg::KIND_REGULAR, 1'h0, egtrc_pkg::ACT_CHANGE, 12'h0c3, 3'h2);
        send(2'h0, egtrc_pkg::KIND_PRIORITY, 1'h0, egtrc_pkg::ACT_CHANGE, 12'h0a1, 3'h2);
        // change-tag alone: priority frames keep their priority, regular frames pass
        wr(16'h1c0c, 32'h00000006);
        send(2'h0, egtrc_pkg::KIND_PRIORITY, 1'h0, egtrc_pkg::ACT_CHANGE, 12'h0a1, 3'h1);
        send(2'h0, egtrc_pkg::KIND_REGULAR, 1'h0, egtrc_pkg::ACT_PASS, 12'h0, 3'h0);
        $display("test decide done");
    endtask
    task automatic pace(input int q, input logic [15:0] i, input logic [31:0] d, input int r);
        int lo;
        wr(i, d);
        @(posedge clk);
        byte_sent <= 6'h1 << q;
        @(posedge clk);
        #1;
        `CHK("other queues", 6'h3f & ~(6'h1 << q), queue_ready & ~(6'h1 << q))
        // the byte stays offered during the gap and must be refused
        lo = 0;
        while (!queue_ready[q] && lo < 40) begin
            lo++;
            @(posedge clk);
            #1;
        end
        `CHK("gap cycles", (r + 1) * 2 - 1, lo)
        @(posedge clk);
        byte_sent <= 6'h0;
        repeat ((r + 1) * 2) @(posedge clk);
    endtask
    task automatic t_pace();
        pace(0, 16'h1c0d, 32'h00000002, 2);
        pace(3, 16'h1c0e, 32'h00002000, 1);
        pace(5, 16'h1c0f, 32'h00006000, 3);
        pace(4, 16'h1c0f, 32'h00006000, 0);
        $display("test pace done");
    endtask
    initial begin
        {n_mismatch, checks, cycles} = '0;
        {reset, reg_wr, reg_rd, req_valid} = 4'h8;
        {reg_index, reg_wdata, byte_sent} = '0;
        req = '0;
        repeat (2) @(posedge clk);
        reset <= 1'h0;
        t_regs();
        t_decide();
        t_pace();
        conclude();
    end
endmodule
`default_nettype wire
